// ### logic/ext_reg_cfg_if.sv
// signals between the register front end and the configuration lock
`timescale 1ns/1ns
interface ext_reg_cfg_if;
	import ext_reg_pkg::*;
	logic sa_write;
	logic sa_value;
	logic ls_write;
	logic ls_value;
	logic fault_clr;
	logic soft_reset;
	cfg_t cfg;
	logic fault;
	modport ctrl (output sa_write, sa_value, ls_write, ls_value, fault_clr, soft_reset,
		input cfg, fault);
	modport lock (input sa_write, sa_value, ls_write, ls_value, fault_clr, soft_reset,
		output cfg, fault);
endinterface

// ### logic/ext_reg_cfg_lock.sv
// one-time configuration lock and the serial access fault flag
`timescale 1ns/1ns
module ext_reg_cfg_lock
	import ext_reg_pkg::*;
(
	// clock and power-on reset
	input wire logic    pclk,
	input wire logic    presetn,
	// front end side
	ext_reg_cfg_if.lock cfg_bus
);
	cfg_t cfg;
	logic fault;
	cfg_t next_cfg;
	logic next_fault;

	// stand-alone wins when both selections arrive together
	wire take_sa = cfg_bus.sa_write & cfg_bus.sa_value & (cfg == cfg_none);
	wire take_ls = cfg_bus.ls_write & cfg_bus.ls_value & (cfg == cfg_none) & !take_sa;
	// only a locked load-share setup reports change attempts
	wire change_try = (cfg == cfg_load_share) &
		((cfg_bus.ls_write & !cfg_bus.ls_value) | (cfg_bus.sa_write & cfg_bus.sa_value));

	// first selection locks; nothing but power-on reset unlocks
	assign next_cfg = take_sa ? cfg_standalone : take_ls ? cfg_load_share : cfg;
	// a new attempt wins over a clear in the same cycle
	assign next_fault = change_try | (fault & !(cfg_bus.fault_clr | cfg_bus.soft_reset));

	// soft reset deliberately not used here so the choice survives it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg   <= cfg_none;
			fault <= 1'b0;
		end else begin
			cfg   <= next_cfg;
			fault <= next_fault;
		end
	end

	assign cfg_bus.cfg   = cfg;
	assign cfg_bus.fault = fault;

	a_lock_sticky: assert property (@(posedge pclk) disable iff (!presetn)
		(cfg != cfg_none) |=> (cfg == $past(cfg)))
		else $error("locked configuration changed");
	a_fault_on_try: assert property (@(posedge pclk) disable iff (!presetn)
		(cfg == cfg_load_share) && cfg_bus.ls_write && !cfg_bus.ls_value |=> fault)
		else $error("change attempt on load share did not raise fault");
	a_sa_no_fault: assert property (@(posedge pclk) disable iff (!presetn)
		(cfg == cfg_standalone) && !fault |=> !fault)
		else $error("fault raised in stand-alone configuration");
	a_sa_priority: assert property (@(posedge pclk) disable iff (!presetn)
		(cfg == cfg_none) && cfg_bus.sa_write && cfg_bus.sa_value |=> (cfg == cfg_standalone))
		else $error("stand-alone selection not captured first");

endmodule // ext_reg_cfg_lock

// ### logic/ext_reg_ctrl.sv
// external-transistor regulator control: apb registers, mode table, stages, flags
// Behaviour
// - writing the stand-alone on bit in Normal mode selects stand-alone use.
// - setting the load-share bit in hardware_control selects load-sharing use.
// - the first selection locks the configuration for the whole power cycle.
// - the locked configuration survives soft reset; only power-on clears it.
// - stand-alone output is 5.0V when voltage select is 0, 3.3V when 1.
// - voltage select has no effect in load-sharing configuration.
// - on/off follows system mode: off in Init and Fail-Safe, table elsewhere.
// - load-sharing follows the main regulator; host configures it in Normal.
// - low battery switches the regulator off; recovery re-enables it.
// - the keep-on bit keeps the regulator enabled during low battery.
// - load-sharing with stop-keep stays active in Stop mode.
// - regulator status is readable in supply_status_two.
// - in Stop the high-power stage joins above rising, leaves below falling.
// - in Normal only the high-power stage runs.
// - changing a locked load-share setup sets the fault flag; stand-alone does not.
// - stand-alone overcurrent sets a flag, clearable only once it is gone.
// - without stop-keep, Stop disables load sharing but keeps the select set.
// - stand-alone undervoltage sets a flag; load-sharing reports none.
`timescale 1ns/1ns
module ext_reg_ctrl
	import ext_reg_pkg::*;
(
	// clock and power-on reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// device state
	input  wire logic        soft_reset,
	input  sys_mode_t        sys_mode,
	input  wire logic        main_reg_on,
	// analog comparators
	input  wire logic        battery_low,
	input  wire logic        base_current_above_rise,
	input  wire logic        base_current_below_fall,
	input  wire logic        shunt_threshold_hit,
	input  wire logic        ext_reg_uv_detect,
	// regulator controls
	output logic             ext_reg_enable,
	output logic             hp_stage_en,
	output logic             lp_stage_en,
	output logic             ext_reg_sel_3v3,
	output logic             load_share_active,
	output logic             current_limit_en
);
	ext_reg_cfg_if cfg_bus ();

	mode_ctrl_t mode_ctrl;
	mode_ctrl_t next_mode_ctrl;
	logic       oc_flag;
	logic       uv_flag;
	logic       hp_boost;
	logic       next_oc_flag;
	logic       next_uv_flag;
	logic       next_hp_boost;
	logic       next_enable;
	logic       next_hp;
	logic       next_lp;
	status_t    status_word;
	logic [31:0] rd_mux;

	ext_reg_cfg_lock ext_reg_cfg_lock_i (
		.pclk    (pclk),
		.presetn (presetn),
		.cfg_bus (cfg_bus.lock)
	);

	// apb decode; zero wait states so pready is simply high
	wire setup    = psel & !penable;
	wire wr_en    = psel & penable & pwrite;
	wire sel_mode = (paddr == off_mode_ctrl);
	wire sel_hw   = (paddr == off_hardware_control);
	wire sel_stat = (paddr == off_status);
	wire sel_flt  = (paddr == off_fault);
	wire sel_ok   = sel_mode | sel_hw | sel_stat | sel_flt;
	wire wr_mode  = wr_en & sel_mode;
	wire wr_hw    = wr_en & sel_hw;
	wire wr_stat  = wr_en & sel_stat;
	wire wr_flt   = wr_en & sel_flt;
	wire in_normal = (sys_mode == mode_normal);
	wire is_sa    = (cfg_bus.cfg == cfg_standalone);
	wire is_ls    = (cfg_bus.cfg == cfg_load_share);
	mode_ctrl_t wr_mode_val;
	assign wr_mode_val = mode_ctrl_t'(pwdata[mode_width-1:0]);
	assign pready = 1'b1;

	// requests to the lock; the on bit counts only in normal mode
	assign cfg_bus.sa_write   = wr_mode & in_normal;
	assign cfg_bus.sa_value   = wr_mode_val.sa_on;
	assign cfg_bus.ls_write   = wr_hw;
	assign cfg_bus.ls_value   = pwdata[bit_ls_sel];
	assign cfg_bus.fault_clr  = wr_flt & pwdata[bit_fault];
	assign cfg_bus.soft_reset = soft_reset;

	// on bit is frozen outside normal and stays clear once load sharing is locked
	wire sa_on_wr = wr_mode & in_normal & !is_ls;
	always_comb begin
		next_mode_ctrl = mode_ctrl;
		if (soft_reset) begin
			next_mode_ctrl = rst_mode_ctrl;
		end else if (wr_mode) begin
			next_mode_ctrl.vsel      = wr_mode_val.vsel;
			next_mode_ctrl.keep_on   = wr_mode_val.keep_on;
			next_mode_ctrl.stop_keep = wr_mode_val.stop_keep;
			if (sa_on_wr) begin
				next_mode_ctrl.sa_on = wr_mode_val.sa_on;
			end
		end
	end

	// load sharing tracks the main regulator; stop drops it unless kept
	wire ls_mode_on = (in_normal | (sys_mode == mode_restart)) ? main_reg_on :
		(sys_mode == mode_stop) ? (mode_ctrl.stop_keep & main_reg_on) : 1'b0;
	// stand-alone holds its software state in stop, sleep and restart
	wire sa_mode_on = ((sys_mode == mode_init) | (sys_mode == mode_fail_safe)) ? 1'b0 :
		mode_ctrl.sa_on;
	wire cfg_on = is_sa ? sa_mode_on : is_ls ? ls_mode_on : 1'b0;
	// no hysteresis here: the battery comparator already provides it
	wire uv_cut = battery_low & !mode_ctrl.keep_on;
	assign next_enable = cfg_on & !uv_cut;

	// stage selection: low-power modes add a current-driven high-power boost
	wire low_power_mode = (sys_mode == mode_stop) | (sys_mode == mode_sleep);
	assign next_hp_boost = !low_power_mode ? 1'b0 :
		base_current_above_rise ? 1'b1 :
		base_current_below_fall ? 1'b0 : hp_boost;
	assign next_hp = next_enable & (!low_power_mode | next_hp_boost);
	assign next_lp = next_enable & low_power_mode;

	// flags: hardware set wins over a software clear in the same cycle
	wire oc_set = is_sa & shunt_threshold_hit;
	wire oc_clr = (wr_stat & pwdata[0] & !shunt_threshold_hit) | soft_reset;
	wire uv_set = is_sa & ext_reg_enable & ext_reg_uv_detect;
	wire uv_clr = (wr_stat & pwdata[1]) | soft_reset;
	assign next_oc_flag = oc_set | (oc_flag & !oc_clr);
	assign next_uv_flag = uv_set | (uv_flag & !uv_clr);

	// control registers and flags
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_ctrl <= rst_mode_ctrl;
			oc_flag   <= 1'b0;
			uv_flag   <= 1'b0;
			hp_boost  <= 1'b0;
		end else begin
			mode_ctrl <= next_mode_ctrl;
			oc_flag   <= next_oc_flag;
			uv_flag   <= next_uv_flag;
			hp_boost  <= next_hp_boost;
		end
	end

	// regulator outputs are registered to keep comparator glitches off the pins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_reg_enable    <= 1'b0;
			hp_stage_en       <= 1'b0;
			lp_stage_en       <= 1'b0;
			ext_reg_sel_3v3   <= 1'b0;
			load_share_active <= 1'b0;
			current_limit_en  <= 1'b0;
		end else begin
			ext_reg_enable    <= next_enable;
			hp_stage_en       <= next_hp;
			lp_stage_en       <= next_lp;
			ext_reg_sel_3v3   <= is_sa & mode_ctrl.vsel;
			load_share_active <= is_ls & next_enable;
			current_limit_en  <= is_sa;
		end
	end

	// read path; hardware_control reads the locked select, which stays set in stop
	assign status_word = '{rsvd: 24'h0, cfg: cfg_bus.cfg, sel_3v3: ext_reg_sel_3v3,
		lp: lp_stage_en, hp: hp_stage_en, en: ext_reg_enable, uv: uv_flag, oc: oc_flag};
	assign rd_mux = sel_mode ? {28'h0, mode_ctrl} :
		sel_hw   ? {31'h0, is_ls} :
		sel_stat ? status_word :
		sel_flt  ? {31'h0, cfg_bus.fault} : 32'h0;

	// read data and error are sampled in the setup phase, valid in the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0;
			pslverr <= 1'b0;
		end else if (setup) begin
			prdata  <= pwrite ? 32'h0 : rd_mux;
			pslverr <= !sel_ok;
		end
	end

	a_init_off: assert property (@(posedge pclk) disable iff (!presetn)
		(sys_mode == mode_init) || (sys_mode == mode_fail_safe) |=> !ext_reg_enable)
		else $error("regulator on in init or fail-safe");
	a_uv_cut: assert property (@(posedge pclk) disable iff (!presetn)
		battery_low && !mode_ctrl.keep_on |=> !ext_reg_enable)
		else $error("regulator not cut on low battery");
	a_uv_reenable: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(battery_low) && in_normal && is_sa && mode_ctrl.sa_on |=> ext_reg_enable)
		else $error("regulator not re-enabled after battery recovery");
	a_keep_on: assert property (@(posedge pclk) disable iff (!presetn)
		battery_low && mode_ctrl.keep_on && in_normal && is_sa && mode_ctrl.sa_on
		|=> ext_reg_enable)
		else $error("keep-on did not hold regulator enabled");
	a_ls_stop_off: assert property (@(posedge pclk) disable iff (!presetn)
		is_ls && (sys_mode == mode_stop) && !mode_ctrl.stop_keep
		|=> !ext_reg_enable && is_ls)
		else $error("load sharing not disabled in stop");
	a_ls_stop_keep: assert property (@(posedge pclk) disable iff (!presetn)
		is_ls && (sys_mode == mode_stop) && mode_ctrl.stop_keep && main_reg_on && !uv_cut
		|=> ext_reg_enable && lp_stage_en)
		else $error("stop-keep did not hold load sharing");
	a_vsel_ignored: assert property (@(posedge pclk) disable iff (!presetn)
		is_ls |=> !ext_reg_sel_3v3)
		else $error("voltage select acted in load sharing");
	a_normal_hp: assert property (@(posedge pclk) disable iff (!presetn)
		in_normal && next_enable |=> hp_stage_en && !lp_stage_en)
		else $error("wrong stage in normal mode");
	a_stop_boost: assert property (@(posedge pclk) disable iff (!presetn)
		(sys_mode == mode_stop) && next_enable && base_current_above_rise
		|=> hp_stage_en && lp_stage_en)
		else $error("high-power stage not added in stop");
	a_oc_hold: assert property (@(posedge pclk) disable iff (!presetn)
		oc_flag && shunt_threshold_hit |=> oc_flag)
		else $error("overcurrent flag cleared while active");

endmodule // ext_reg_ctrl

// ### logic/ext_reg_pkg.sv
// shared constants and types for the external regulator control block
package ext_reg_pkg;

	// register byte offsets on the apb slave
	localparam logic [7:0] off_mode_ctrl = 8'h00;
	localparam logic [7:0] off_hardware_control   = 8'h04;
	localparam logic [7:0] off_status    = 8'h08;
	localparam logic [7:0] off_fault     = 8'h0c;

	// field positions in hardware_control and the fault register
	localparam int bit_ls_sel = 0;
	localparam int bit_fault  = 0;
	localparam int mode_width = 4;

	// system modes reported by the mode controller
	typedef enum logic [2:0] {
		mode_init,
		mode_normal,
		mode_stop,
		mode_sleep,
		mode_restart,
		mode_fail_safe
	} sys_mode_t;

	// regulator configuration, chosen once per power cycle
	typedef enum logic [1:0] {
		cfg_none,
		cfg_standalone,
		cfg_load_share
	} cfg_t;

	// mode_supply_control layout, low bits of the word
	typedef struct packed {
		logic stop_keep;
		logic keep_on;
		logic vsel;
		logic sa_on;
	} mode_ctrl_t;

	// supply_status_two layout
	typedef struct packed {
		logic [23:0] rsvd;
		cfg_t        cfg;
		logic        sel_3v3;
		logic        lp;
		logic        hp;
		logic        en;
		logic        uv;
		logic        oc;
	} status_t;

	// values after reset
	localparam mode_ctrl_t rst_mode_ctrl = 4'h0;

endpackage

// ### sim/ext_regulator_config_ctrl_tb_top.sv
// register-level testbench for the external regulator control block
`timescale 1ns/1ns
module ext_regulator_config_ctrl_tb_top;
	import ext_reg_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, soft_reset, main_reg_on, battery_low;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic        pready, pslverr, en, hp, lp, sel, ls, cl;
	logic        rise, fall, shunt, uv, heavy, over, short_out;
	sys_mode_t   mode;
	int          mismatches, tests_run;

	ext_reg_ctrl ext_reg_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .soft_reset(soft_reset),
		.sys_mode(mode), .main_reg_on(main_reg_on), .battery_low(battery_low),
		.base_current_above_rise(rise), .base_current_below_fall(fall),
		.shunt_threshold_hit(shunt), .ext_reg_uv_detect(uv), .ext_reg_enable(en),
		.hp_stage_en(hp), .lp_stage_en(lp), .ext_reg_sel_3v3(sel),
		.load_share_active(ls), .current_limit_en(cl));
	pass_transistor_model pass_transistor_model_i (.ext_reg_enable(en),
		.heavy_load(heavy), .overload(over), .output_short(short_out),
		.above_rise(rise), .below_fall(fall), .shunt_hit(shunt), .uv_detect(uv));

	// 100 MHz clock
	always #5 pclk = ~pclk;

	task print_verdict;
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// one apb transfer; request held until pready is seen at a rising edge
	// no cycle count is assumed here: only the watchdog ends a stuck wait
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t register got %h expected %h", $time, got, exp);
		end
	endtask

	// pins are registered, so let the comparator loop settle first
	// sampled mid-cycle, away from the edge that updates them
	task pins(input logic [5:0] exp);
		repeat (3) @(posedge pclk);
		@(negedge pclk);
		tests_run++;
		if ({en, hp, lp, sel, ls, cl} !== exp) begin
			mismatches++;
			$display("BAD %0t pins got %b expected %b", $time, {en, hp, lp, sel, ls, cl}, exp);
		end
		@(posedge pclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 32'h0, q, e);
		chk(q & m, exp);
	endtask

	task por;
		presetn <= 1'b0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
	endtask

	// watchdog well beyond the few hundred cycles the sequence needs
	initial begin
		repeat (20000) @(posedge pclk);
		mismatches++;
		print_verdict;
	end

	initial begin : main
		logic [31:0] q;
		logic        e;
		{pclk, presetn, psel, penable, pwrite, soft_reset, main_reg_on, battery_low} = 8'h00;
		{paddr, pwdata, heavy, over, short_out} = 43'h0;
		mode = mode_init;
		mismatches = 0;
		tests_run = 0;
		por;
		pins(6'h00);
		rchk(off_status, 32'h0, 32'hffff_ffff);
		apb(1'b0, 8'h10, 32'h0, q, e);
		chk({31'h0, e}, 32'h1);
		// a stand-alone request outside normal mode must not lock
		wr(off_mode_ctrl, 32'h1);
		rchk(off_status, 32'h0, 32'hc0);
		mode <= mode_normal;
		pins(6'h00);
		wr(off_mode_ctrl, 32'h3);
		pins(6'b110101);
		rchk(off_status, 32'h6c, 32'hfc);
		wr(off_hardware_control, 32'h1);
		rchk(off_status, 32'h40, 32'hc0);
		rchk(off_hardware_control, 32'h0, 32'h1);
		rchk(off_fault, 32'h0, 32'h1);
		wr(off_mode_ctrl, 32'h2);
		pins(6'b000101);
		wr(off_mode_ctrl, 32'h1);
		pins(6'b110001);
		battery_low <= 1'b1;
		pins(6'b000001);
		wr(off_mode_ctrl, 32'h5);
		pins(6'b110001);
		wr(off_mode_ctrl, 32'h1);
		pins(6'b000001);
		battery_low <= 1'b0;
		pins(6'b110001);
		mode <= mode_stop;
		pins(6'b101001);
		heavy <= 1'b1;
		pins(6'b111001);
		heavy <= 1'b0;
		pins(6'b101001);
		mode <= mode_sleep;
		pins(6'b101001);
		mode <= mode_restart;
		pins(6'b110001);
		mode <= mode_fail_safe;
		pins(6'b000001);
		mode <= mode_normal;
		over <= 1'b1;
		pins(6'b110001);
		wr(off_status, 32'h1);
		rchk(off_status, 32'h1, 32'h1);
		over <= 1'b0;
		wr(off_status, 32'h1);
		rchk(off_status, 32'h0, 32'h1);
		short_out <= 1'b1;
		// the flag lands one edge after the comparator, before the read setup
		repeat (2) @(posedge pclk);
		rchk(off_status, 32'h2, 32'h2);
		short_out <= 1'b0;
		wr(off_status, 32'h2);
		rchk(off_status, 32'h0, 32'h2);
		soft_reset <= 1'b1;
		repeat (2) @(posedge pclk);
		soft_reset <= 1'b0;
		pins(6'b000001);
		rchk(off_status, 32'h40, 32'hc0);
		por;
		rchk(off_status, 32'h0, 32'hc0);
		// load sharing, configured by the host in normal mode at once
		mode <= mode_normal;
		main_reg_on <= 1'b1;
		wr(off_hardware_control, 32'h1);
		pins(6'b110010);
		rchk(off_status, 32'h80, 32'hc0);
		wr(off_mode_ctrl, 32'h2);
		pins(6'b110010);
		rchk(off_fault, 32'h0, 32'h1);
		wr(off_hardware_control, 32'h0);
		rchk(off_fault, 32'h1, 32'h1);
		rchk(off_hardware_control, 32'h1, 32'h1);
		wr(off_fault, 32'h1);
		rchk(off_fault, 32'h0, 32'h1);
		main_reg_on <= 1'b0;
		pins(6'h00);
		main_reg_on <= 1'b1;
		mode <= mode_stop;
		pins(6'h00);
		rchk(off_hardware_control, 32'h1, 32'h1);
		mode <= mode_normal;
		pins(6'b110010);
		wr(off_mode_ctrl, 32'h8);
		mode <= mode_stop;
		pins(6'b101010);
		mode <= mode_sleep;
		pins(6'h00);
		mode <= mode_restart;
		pins(6'b110010);
		over <= 1'b1;
		short_out <= 1'b1;
		repeat (2) @(posedge pclk);
		rchk(off_status, 32'h0, 32'h3);
		battery_low <= 1'b1;
		pins(6'h00);
		print_verdict;
	end
endmodule // ext_regulator_config_ctrl_tb_top

// ### sim/pass_transistor_model.sv
// behavioural model of the external pass transistor, shunt and load
`timescale 1ns/1ns
module pass_transistor_model (
	// regulator drive from the block
	input  wire logic ext_reg_enable,
	// load conditions commanded by the bench
	input  wire logic heavy_load,
	input  wire logic overload,
	input  wire logic output_short,
	// comparator levels back to the block
	output logic      above_rise,
	output logic      below_fall,
	output logic      shunt_hit,
	output logic      uv_detect
);
	// an unpowered transistor carries no base current, so above_rise, shunt_hit and uv_detect read low and below_fall reads high
	assign above_rise = ext_reg_enable & heavy_load;
	assign below_fall = ~(ext_reg_enable & heavy_load);
	assign shunt_hit  = ext_reg_enable & overload;
	assign uv_detect  = ext_reg_enable & output_short;
endmodule // pass_transistor_model
